// ### verilog/tcpc_pkg.sv
// shared constants, types and register map of the timer compare/pwm block
package tcpc_pkg;

    localparam int unsigned CLK_FREQ_HZ = 10_000_000;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_CMP_A = 8'h0c;
    localparam logic [7:0] OFS_CMP_B = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // control_reg_a field positions
    localparam int unsigned POS_ACT_A = 6;
    localparam int unsigned POS_ACT_B = 4;
    localparam int unsigned POS_WAVE_LOW = 0;
    // control_reg_b field positions
    localparam int unsigned POS_FORCE_A = 7;
    localparam int unsigned POS_FORCE_B = 6;
    localparam int unsigned POS_WAVE_TOP = 3;
    localparam int unsigned POS_CLK_SEL = 0;
    // status field positions
    localparam int unsigned POS_OVF = 0;
    localparam int unsigned POS_CMP_A_FLAG = 1;
    localparam int unsigned POS_CMP_B_FLAG = 2;

    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    // prescaler tap masks for divide by 8, 64, 256 and 1024
    localparam logic [9:0] PRE_MASK_8 = 10'h007;
    localparam logic [9:0] PRE_MASK_64 = 10'h03f;
    localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
    localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

    // clock select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIRECT = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // waveform mode codes
    localparam logic [2:0] WM_NORMAL = 3'h0;
    localparam logic [2:0] WM_PC_FF = 3'h1;
    localparam logic [2:0] WM_CTC = 3'h2;
    localparam logic [2:0] WM_FAST_FF = 3'h3;
    localparam logic [2:0] WM_PC_CMP = 3'h5;
    localparam logic [2:0] WM_FAST_CMP = 3'h7;

    typedef enum logic [3:0] {
        KIND_NONPWM = 4'b0001,
        KIND_FAST = 4'b0010,
        KIND_PHASE = 4'b0100,
        KIND_RSVD = 4'b1000
    } tcpc_kind_e;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } tcpc_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tcpc_apb_rsp_s;

    typedef struct packed {
        logic [1:0] act_a;
        logic [1:0] act_b;
        logic [1:0] wave_low;
        logic wave_top;
        logic [2:0] clk_sel;
        logic [7:0] count;
        logic [7:0] cmp_a_buf;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b_buf;
        logic [7:0] cmp_b;
        logic count_down;
        logic match_block;
        logic ovf_flag;
        logic cmp_a_flag;
        logic cmp_b_flag;
        logic out_a;
        logic out_b;
        logic [9:0] presc;
        logic pin_meta;
        logic pin_sync;
        logic pin_prev;
        logic [31:0] rdata;
    } tcpc_state_s;

    localparam tcpc_state_s STATE_RESET = '0;

endpackage

// ### verilog/tcpc_timer.sv
// 8-bit timer/counter with two compare channels behind an apb slave
// Operation
// - nonzero channel B action overrides pin; driver needs direction bit set
// - non-pwm channel B: disconnected, toggle, clear or set on match
// - fast pwm channel B: 10 clear on match set at top, 11 reverse
// - phase pwm channel B: 10 clear up-match set down-match, 11 reverse
// - pwm with compare equal top and upper bit: act at top only
// - mode code picks sequence, top and wave; modes 0,2 update immediately
// - modes 1,5 phase pwm, 3,7 fast pwm; update at top; 4,6 reserved
// - overflow at max in 0,2,3, bottom in phase pwm, top in 7
// - forced compare strobes act only in non-pwm modes
// - strobe applies a match now using the current action field
// - forced compare raises no flag and never clears the counter
// - strobe bits always read zero
// - reserved control bits read zero
// - clock select: stop, direct, or prescaler taps 8/64/256/1024
// - codes 110 and 111 count falling and rising pin edges
// - pin edges count even when the pin is an output
// - counter register gives direct read and write of the count
// - a counter write blocks compare match on the next tick
// - channel A compare value is matched against counter each tick
// - pwm channel A action 01 toggles on match only if top bit set
// - phase pwm counts up to top, holds one tick, counts down
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module tcpc_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire tcpc_pkg::tcpc_apb_req_s apb_req,
    output tcpc_pkg::tcpc_apb_rsp_s apb_rsp,
    input wire logic ext_timer_clock_pin,
    input wire logic port_dir_a,
    input wire logic port_dir_b,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic pin_override_a,
    output logic pin_override_b,
    output logic pin_oe_a_n,
    output logic pin_oe_b_n
);

    tcpc_pkg::tcpc_state_s st;
    tcpc_pkg::tcpc_state_s next_st;

    // next waveform level of one channel
    function automatic logic wave_next(
        input logic cur,
        input logic [1:0] act,
        input logic is_a,
        input logic top_bit,
        input tcpc_pkg::tcpc_kind_e kind,
        input logic match,
        input logic at_top,
        input logic down,
        input logic cmp_is_top
    );
        logic r;
        r = cur;
        case (kind)
            tcpc_pkg::KIND_NONPWM: begin
                if (match) begin
                    case (act)
                        2'h1: r = ~cur;
                        2'h2: r = 1'b0;
                        2'h3: r = 1'b1;
                        default: r = cur;
                    endcase
                end
            end
            tcpc_pkg::KIND_FAST: begin
                if (act[1]) begin
                    // top action wins, match ignored when compare is top
                    if (at_top) begin
                        r = ~act[0];
                    end else if (match && !cmp_is_top) begin
                        r = act[0];
                    end
                end else if (act[0] && is_a && top_bit && match) begin
                    r = ~cur;
                end
            end
            tcpc_pkg::KIND_PHASE: begin
                if (act[1]) begin
                    if (match && cmp_is_top) begin
                        r = ~act[0];
                    end else if (match) begin
                        r = down ? ~act[0] : act[0];
                    end
                end else if (act[0] && is_a && top_bit && match) begin
                    r = ~cur;
                end
            end
            default: r = cur;
        endcase
        return r;
    endfunction

    logic [2:0] mode_code;
    tcpc_pkg::tcpc_kind_e kind;
    logic [7:0] top_value;
    logic tick;
    logic ext_rise;
    logic ext_fall;
    logic at_top;
    logic match_a;
    logic match_b;
    logic ovf_event;
    logic wr;
    logic rd_setup;
    logic addr_ok;
    logic force_a;
    logic force_b;
    logic [7:0] wbyte;
    logic [31:0] rd_mux;

    assign mode_code = {st.wave_top, st.wave_low};
    assign wbyte = apb_req.pwdata[7:0];
    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite & addr_ok;
    assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

    always_comb begin
        case (apb_req.paddr)
            tcpc_pkg::OFS_CTRL_A,
            tcpc_pkg::OFS_CTRL_B,
            tcpc_pkg::OFS_COUNT,
            tcpc_pkg::OFS_CMP_A,
            tcpc_pkg::OFS_CMP_B,
            tcpc_pkg::OFS_STATUS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // mode decode
    always_comb begin
        case (mode_code)
            tcpc_pkg::WM_NORMAL,
            tcpc_pkg::WM_CTC: kind = tcpc_pkg::KIND_NONPWM;
            tcpc_pkg::WM_PC_FF,
            tcpc_pkg::WM_PC_CMP: kind = tcpc_pkg::KIND_PHASE;
            tcpc_pkg::WM_FAST_FF,
            tcpc_pkg::WM_FAST_CMP: kind = tcpc_pkg::KIND_FAST;
            default: kind = tcpc_pkg::KIND_RSVD;
        endcase
        case (mode_code)
            tcpc_pkg::WM_CTC,
            tcpc_pkg::WM_PC_CMP,
            tcpc_pkg::WM_FAST_CMP: top_value = st.cmp_a;
            default: top_value = tcpc_pkg::COUNT_MAX;
        endcase
    end

    // edge detect compares the second synchroniser stage with its one-cycle delayed copy
    assign ext_rise = st.pin_sync & ~st.pin_prev;
    assign ext_fall = ~st.pin_sync & st.pin_prev;

    always_comb begin
        case (st.clk_sel)
            tcpc_pkg::CS_STOP: tick = 1'b0;
            tcpc_pkg::CS_DIRECT: tick = 1'b1;
            tcpc_pkg::CS_DIV8:
                tick = (st.presc & tcpc_pkg::PRE_MASK_8)
                    == tcpc_pkg::PRE_MASK_8;
            tcpc_pkg::CS_DIV64:
                tick = (st.presc & tcpc_pkg::PRE_MASK_64)
                    == tcpc_pkg::PRE_MASK_64;
            tcpc_pkg::CS_DIV256:
                tick = (st.presc & tcpc_pkg::PRE_MASK_256)
                    == tcpc_pkg::PRE_MASK_256;
            tcpc_pkg::CS_DIV1024:
                tick = st.presc == tcpc_pkg::PRE_MASK_1024;
            // pin is used whatever its direction
            tcpc_pkg::CS_EXT_FALL: tick = ext_fall;
            tcpc_pkg::CS_EXT_RISE: tick = ext_rise;
            default: tick = 1'b0;
        endcase
    end

    assign at_top = tick & (st.count == top_value);
    assign match_a = tick & ~st.match_block
        & (st.count == st.cmp_a);
    assign match_b = tick & ~st.match_block & (st.count == st.cmp_b);

    always_comb begin
        case (mode_code)
            tcpc_pkg::WM_NORMAL,
            tcpc_pkg::WM_CTC,
            tcpc_pkg::WM_FAST_FF:
                ovf_event = tick & (st.count == tcpc_pkg::COUNT_MAX);
            tcpc_pkg::WM_PC_FF,
            tcpc_pkg::WM_PC_CMP:
                ovf_event = tick & st.count_down
                    & (st.count == tcpc_pkg::COUNT_BOTTOM);
            tcpc_pkg::WM_FAST_CMP: ovf_event = at_top;
            default: ovf_event = 1'b0;
        endcase
    end

    // strobes only in non-pwm modes; pwm writes of strobes are ignored
    assign force_a = wr & (apb_req.paddr == tcpc_pkg::OFS_CTRL_B)
        & wbyte[tcpc_pkg::POS_FORCE_A]
        & (kind == tcpc_pkg::KIND_NONPWM);
    assign force_b = wr & (apb_req.paddr == tcpc_pkg::OFS_CTRL_B)
        & wbyte[tcpc_pkg::POS_FORCE_B]
        & (kind == tcpc_pkg::KIND_NONPWM);

    always_comb begin
        rd_mux = '0;
        case (apb_req.paddr)
            tcpc_pkg::OFS_CTRL_A:
                rd_mux[7:0] = {st.act_a, st.act_b, 2'h0,
                    st.wave_low};
            tcpc_pkg::OFS_CTRL_B:
                rd_mux[7:0] = {2'h0, 2'h0, st.wave_top,
                    st.clk_sel};
            tcpc_pkg::OFS_COUNT: rd_mux[7:0] = st.count;
            tcpc_pkg::OFS_CMP_A: rd_mux[7:0] = st.cmp_a_buf;
            tcpc_pkg::OFS_CMP_B: rd_mux[7:0] = st.cmp_b_buf;
            tcpc_pkg::OFS_STATUS:
                rd_mux[2:0] = {st.cmp_b_flag, st.cmp_a_flag, st.ovf_flag};
            default: rd_mux = '0;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.presc = st.presc + 10'h001;
        next_st.pin_meta = ext_timer_clock_pin;
        next_st.pin_sync = st.pin_meta;
        next_st.pin_prev = st.pin_sync;
        if (rd_setup) begin
            next_st.rdata = rd_mux;
        end

        // counting sequence
        if (tick) begin
            next_st.match_block = 1'b0;
            if (kind == tcpc_pkg::KIND_PHASE) begin
                if (!st.count_down) begin
                    if (st.count == top_value) begin
                        // top lasts one tick, then turn round
                        next_st.count_down = 1'b1;
                        next_st.count = st.count - 8'h01;
                    end else begin
                        next_st.count = st.count + 8'h01;
                    end
                end else if (st.count == tcpc_pkg::COUNT_BOTTOM) begin
                    next_st.count_down = 1'b0;
                    next_st.count = st.count + 8'h01;
                end else begin
                    next_st.count = st.count - 8'h01;
                end
            end else if (st.count == top_value) begin
                next_st.count = tcpc_pkg::COUNT_BOTTOM;
                next_st.count_down = 1'b0;
            end else begin
                next_st.count = st.count + 8'h01;
                next_st.count_down = 1'b0;
            end
        end

        // double-buffered compare values load at top in pwm modes
        if (at_top && (kind == tcpc_pkg::KIND_FAST
                || kind == tcpc_pkg::KIND_PHASE)) begin
            next_st.cmp_a = st.cmp_a_buf;
            next_st.cmp_b = st.cmp_b_buf;
        end

        next_st.out_a = wave_next(st.out_a, st.act_a, 1'b1, st.wave_top,
            kind, match_a, at_top, st.count_down, st.cmp_a == top_value);
        next_st.out_b = wave_next(st.out_b, st.act_b, 1'b0, st.wave_top,
            kind, match_b, at_top, st.count_down, st.cmp_b == top_value);
        // forced match uses the action field as it stands now
        if (force_a) begin
            next_st.out_a = wave_next(st.out_a, st.act_a, 1'b1, st.wave_top,
                kind, 1'b1, 1'b0, 1'b0, 1'b0);
        end
        if (force_b) begin
            next_st.out_b = wave_next(st.out_b, st.act_b, 1'b0, st.wave_top,
                kind, 1'b1, 1'b0, 1'b0, 1'b0);
        end

        // software writes; hardware set wins over write-one clear
        if (wr) begin
            case (apb_req.paddr)
                tcpc_pkg::OFS_CTRL_A: begin
                    next_st.act_a = wbyte[tcpc_pkg::POS_ACT_A +: 2];
                    next_st.act_b = wbyte[tcpc_pkg::POS_ACT_B +: 2];
                    next_st.wave_low = wbyte[tcpc_pkg::POS_WAVE_LOW +: 2];
                end
                tcpc_pkg::OFS_CTRL_B: begin
                    next_st.wave_top = wbyte[tcpc_pkg::POS_WAVE_TOP];
                    next_st.clk_sel = wbyte[tcpc_pkg::POS_CLK_SEL +: 3];
                end
                tcpc_pkg::OFS_COUNT: begin
                    next_st.count = wbyte;
                    next_st.match_block = 1'b1;
                end
                tcpc_pkg::OFS_CMP_A: begin
                    next_st.cmp_a_buf = wbyte;
                    if (kind == tcpc_pkg::KIND_NONPWM
                            || kind == tcpc_pkg::KIND_RSVD) begin
                        next_st.cmp_a = wbyte;
                    end
                end
                tcpc_pkg::OFS_CMP_B: begin
                    next_st.cmp_b_buf = wbyte;
                    if (kind == tcpc_pkg::KIND_NONPWM
                            || kind == tcpc_pkg::KIND_RSVD) begin
                        next_st.cmp_b = wbyte;
                    end
                end
                tcpc_pkg::OFS_STATUS: begin
                    if (wbyte[tcpc_pkg::POS_OVF]) begin
                        next_st.ovf_flag = 1'b0;
                    end
                    if (wbyte[tcpc_pkg::POS_CMP_A_FLAG]) begin
                        next_st.cmp_a_flag = 1'b0;
                    end
                    if (wbyte[tcpc_pkg::POS_CMP_B_FLAG]) begin
                        next_st.cmp_b_flag = 1'b0;
                    end
                end
                default: next_st.count = next_st.count;
            endcase
        end
        // flags come only from counting events (overflow and compare matches), never from strobes
        if (ovf_event) begin
            next_st.ovf_flag = 1'b1;
        end
        if (match_a) begin
            next_st.cmp_a_flag = 1'b1;
        end
        if (match_b) begin
            next_st.cmp_b_flag = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= tcpc_pkg::STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // zero-wait slave; read data captured in the setup cycle
    assign apb_rsp.prdata = st.rdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_ok;

    assign wave_out_a = st.out_a;
    assign wave_out_b = st.out_b;
    assign pin_override_a = |st.act_a;
    assign pin_override_b = |st.act_b;
    assign pin_oe_a_n = ~(pin_override_a & port_dir_a);
    assign pin_oe_b_n = ~(pin_override_b & port_dir_b);

endmodule

// ### sim/tcpc_timer_checker.sv
// assertion checker for the timer compare/pwm block, bound to its top
`timescale 1ns/1ps
module tcpc_timer_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire tcpc_pkg::tcpc_apb_req_s apb_req,
    input wire tcpc_pkg::tcpc_apb_rsp_s apb_rsp,
    input wire logic ext_timer_clock_pin,
    input wire logic port_dir_a,
    input wire logic port_dir_b,
    input wire logic wave_out_a,
    input wire logic wave_out_b,
    input wire logic pin_override_a,
    input wire logic pin_override_b,
    input wire logic pin_oe_a_n,
    input wire logic pin_oe_b_n
);
    logic acc;
    logic wr;
    logic wr_a;
    logic wr_b;
    logic mapped;
    logic [1:0] act_b;
    logic low0;
    logic top;
    logic [2:0] cs;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    assign acc = apb_req.psel && apb_req.penable;
    assign wr = acc && apb_req.pwrite;
    assign wr_a = wr && apb_req.paddr == tcpc_pkg::OFS_CTRL_A;
    assign wr_b = wr && apb_req.paddr == tcpc_pkg::OFS_CTRL_B;
    assign mapped = apb_req.paddr[1:0] == 2'h0 &&
        apb_req.paddr <= tcpc_pkg::OFS_STATUS;

    // shadows rebuilt from bus writes, the fields are not visible here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_b <= 2'h0;
            low0 <= 1'b0;
            top <= 1'b0;
            cs <= 3'h0;
        end else begin
            if (wr_a) begin
                act_b <= apb_req.pwdata[5:4];
                low0 <= apb_req.pwdata[0];
            end
            if (wr_b) begin
                top <= apb_req.pwdata[3];
                cs <= apb_req.pwdata[2:0];
            end
        end
    end

    sequence s_ctrl_a_write;
        wr_a;
    endsequence
    // forced compare in a non-pwm mode with the counter stopped
    sequence s_force_b;
        wr_b && apb_req.pwdata[6] && !low0 && !top &&
            cs == tcpc_pkg::CS_STOP && apb_req.pwdata[3:0] == 4'h0;
    endsequence

    chk_oe_b_gate: assert property
        (pin_oe_b_n == !(pin_override_b && port_dir_b))
        else $error("channel b driver enable wrong");
    chk_override_b: assert property
        (s_ctrl_a_write |=> pin_override_b == $past(|apb_req.pwdata[5:4]))
        else $error("channel b override does not follow action");
    chk_strobe_zero: assert property
        (acc && !apb_req.pwrite && apb_req.paddr == tcpc_pkg::OFS_CTRL_B
            |-> apb_rsp.prdata[7:4] == 4'h0)
        else $error("control b strobe or reserved bits read nonzero");
    chk_rsvd_zero: assert property
        (acc && !apb_req.pwrite && apb_req.paddr == tcpc_pkg::OFS_CTRL_A
            |-> apb_rsp.prdata[3:2] == 2'h0)
        else $error("control a reserved bits read nonzero");
    chk_bad_addr: assert property
        (acc |-> apb_rsp.pslverr == !mapped && apb_rsp.pready)
        else $error("slave error does not match address");
    chk_stopped_hold: assert property
        (cs == tcpc_pkg::CS_STOP && !wr_b
            |=> $stable(wave_out_a) && $stable(wave_out_b))
        else $error("waveform moved with counter stopped");
    chk_force_toggle: assert property
        (s_force_b ##0 act_b == 2'h1 |=> wave_out_b != $past(wave_out_b))
        else $error("forced toggle on channel b missing");
    chk_force_level: assert property
        (s_force_b ##0 act_b[1] |=> wave_out_b == act_b[0])
        else $error("forced set or clear on channel b wrong");
    chk_force_pwm: assert property
        (wr_b && apb_req.pwdata[7:6] != 2'h0 && low0 &&
            cs == tcpc_pkg::CS_STOP && apb_req.pwdata[2:0] == 3'h0
            |=> $stable(wave_out_a) && $stable(wave_out_b))
        else $error("forced compare acted in a pwm mode");
endmodule

bind tcpc_timer tcpc_timer_checker u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .ext_timer_clock_pin(ext_timer_clock_pin),
    .port_dir_a(port_dir_a),
    .port_dir_b(port_dir_b),
    .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b),
    .pin_override_a(pin_override_a),
    .pin_override_b(pin_override_b),
    .pin_oe_a_n(pin_oe_a_n),
    .pin_oe_b_n(pin_oe_b_n)
);

// ### sim/testbench.sv
// self-checking testbench of the timer compare/pwm block
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] A_CA = tcpc_pkg::OFS_CTRL_A;
    localparam logic [7:0] A_CB = tcpc_pkg::OFS_CTRL_B;
    localparam logic [7:0] A_CN = tcpc_pkg::OFS_COUNT;
    localparam logic [7:0] A_CMP = tcpc_pkg::OFS_CMP_A;
    localparam logic [7:0] A_CMB = tcpc_pkg::OFS_CMP_B;
    logic pclk;
    logic presetn;
    logic ext_pin;
    logic dir_a;
    logic dir_b;
    logic wave_a;
    logic wave_b;
    logic ovr_a;
    logic ovr_b;
    logic oe_a_n;
    logic oe_b_n;
    tcpc_pkg::tcpc_apb_req_s req;
    tcpc_pkg::tcpc_apb_rsp_s rsp;
    int failures = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic err;

    tcpc_timer dut (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(req),
        .apb_rsp(rsp),
        .ext_timer_clock_pin(ext_pin),
        .port_dir_a(dir_a),
        .port_dir_b(dir_b),
        .wave_out_a(wave_a),
        .wave_out_b(wave_b),
        .pin_override_a(ovr_a),
        .pin_override_b(ovr_b),
        .pin_oe_a_n(oe_a_n),
        .pin_oe_b_n(oe_b_n)
    );

    always #50 pclk = ~pclk;

    task automatic check(input string n, input logic [31:0] s,
                         input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    // entered just after an edge; one idle edge keeps strobes apart
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1) @(posedge pclk);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string n, input logic [7:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(n, rd, e);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic t_regs();
        rdchk("ctrl_a", A_CA, 32'h0);
        rdchk("count", A_CN, 32'h0);
        wr(A_CA, 32'hffff_ffff);
        rdchk("ctrl_a", A_CA, 32'hf3);
        check("override_b", ovr_b, 1'b1);
        check("override_a", ovr_a, 1'b1);
        check("oe_b_n", oe_b_n, 1'b0);
        check("oe_a_n", oe_a_n, 1'b1);
        wr(A_CB, 32'hfe);
        rdchk("ctrl_b", A_CB, 32'h0e);
        wr(A_CB, 32'h0);
        wr(A_CA, 32'h0);
        wr(A_CN, 32'h5a);
        rdchk("count", A_CN, 32'h5a);
        wr(A_CMP, 32'ha5);
        rdchk("cmp_a", A_CMP, 32'ha5);
        wr(8'h1c, 32'h1);
        check("pslverr", err, 1'b1);
        rdchk("unmapped", 8'h1c, 32'h0);
        $display("test registers done");
    endtask

    task automatic t_force();
        logic [9:0] acts = 10'b11_10_01_01_11;
        logic [4:0] exp = 5'b10101;
        for (int i = 0; i < 5; i++) begin
            wr(A_CA, {24'h0, acts[2*i+:2], acts[2*i+:2], 4'h0});
            wr(A_CB, 32'hc0);
            check("force b", wave_b, exp[i]);
            check("force a", wave_a, exp[i]);
        end
        wr(A_CA, 32'h51);
        wr(A_CB, 32'hc0);
        check("pwm force", {wave_a, wave_b}, 2'h3);
        wr(A_CA, 32'h52);
        wr(A_CN, 32'h3);
        wr(A_CMP, 32'h3);
        wr(A_CB, 32'h80);
        check("ctc force", {wave_a, wave_b}, 2'h1);
        rdchk("count kept", A_CN, 32'h3);
        rdchk("no flag", tcpc_pkg::OFS_STATUS, 32'h0);
        wr(A_CA, 32'h0);
        check("disconnected", ovr_b, 1'b0);
        $display("test force done");
    endtask

    task automatic t_clock();
        int divs [6] = '{0, 1, 8, 64, 256, 1024};
        // write edges 10*divisor apart, so exactly ten taps land between
        for (int c = 0; c < 6; c++) begin
            wr(A_CN, 32'h0);
            wr(A_CB, c);
            repeat (divs[c] == 0 ? 20 : 10 * divs[c] - 3) @(posedge pclk);
            wr(A_CB, 32'h0);
            rdchk("ticks", A_CN, divs[c] == 0 ? 32'h0 : 32'ha);
        end
        for (int k = 0; k < 2; k++) begin
            wr(A_CN, 32'h0);
            wr(A_CB, k ? 32'h6 : 32'h7);
            repeat (5) begin
                ext_pin <= 1'b1;
                repeat (3) @(posedge pclk);
                ext_pin <= 1'b0;
                repeat (3) @(posedge pclk);
            end
            repeat (3) @(posedge pclk);
            wr(A_CB, 32'h0);
            rdchk("pin edges", A_CN, 32'h5);
        end
        $display("test clock select done");
    endtask

    task automatic t_block();
        logic w;
        wr(A_CA, 32'h40);
        wr(A_CMP, 32'h5);
        wr(A_CN, 32'h80);
        wr(A_CB, 32'h1);
        w = wave_a;
        wr(A_CN, 32'h5);
        repeat (5) begin
            @(negedge pclk);
            check("blocked match", wave_a, w);
        end
        repeat (256) @(posedge pclk);
        check("later match", wave_a, !w);
        wr(A_CB, 32'h0);
        // the wrap through max and the matches at 0 and 5 left all flags up
        rdchk("flags", tcpc_pkg::OFS_STATUS, 32'h7);
        wr(tcpc_pkg::OFS_STATUS, 32'h7);
        rdchk("flags cleared", tcpc_pkg::OFS_STATUS, 32'h0);
        $display("test counter write done");
    endtask

    task automatic t_pwm();
        int ca [5] = '{'h23, 'h33, 'h23, 'h21, 'h31};
        int cb [5] = '{'h40, 'h40, 'hff, 'h40, 'h40};
        int ns [5] = '{512, 512, 512, 1020, 1020};
        int ex [5] = '{130, 382, 512, 256, 764};
        logic [31:0] hi;
        for (int k = 0; k < 5; k++) begin
            // strobes stay zero while a pwm mode runs
            wr(A_CB, 32'h0);
            wr(A_CMB, cb[k]);
            wr(A_CA, ca[k]);
            wr(A_CB, 32'h1);
            hi = 32'h0;
            repeat (600) @(posedge pclk);
            repeat (ns[k]) begin
                @(negedge pclk);
                hi += wave_b;
            end
            check("duty", hi, ex[k]);
        end
        $display("test pwm done");
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        req = '0;
        ext_pin = 1'b0;
        dir_a = 1'b0;
        dir_b = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_force();
        t_clock();
        t_block();
        t_pwm();
        wrap_up();
    end

    // about twice the expected length of the whole run
    initial begin
        #4_000_000;
        failures++;
        wrap_up();
    end
endmodule
